/* verilog/move_exec_pkg.sv */
package move_exec_pkg;
  localparam int          INSN_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          FADDR_W       = 7;
  // opcode patterns, compared under masks
  localparam logic [13:0] LOAD_LIT_MASK = 14'h3c00;
  localparam logic [13:0] LOAD_LIT_PAT  = 14'h3000;
  localparam logic [13:0] COPY_REG_MASK = 14'h3f00;
  localparam logic [13:0] COPY_REG_PAT  = 14'h0800;
  localparam logic [13:0] STORE_ACC_MASK = 14'h3f80;
  localparam logic [13:0] STORE_ACC_PAT = 14'h0080;
  localparam logic [13:0] IDLE_MASK     = 14'h3f9f;
  localparam logic [13:0] IDLE_PAT      = 14'h0000;
  localparam int          DEST_BIT      = 7;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic        ZERO_RESET    = 1'b0;
  localparam logic [6:0]  WADDR_RESET   = 7'h00;
  localparam logic [7:0]  WDATA_RESET   = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE, OP_LOAD_LIT, OP_COPY_REG, OP_STORE_ACC, OP_IDLE
  } op_kind_e;
endpackage : move_exec_pkg

/* verilog/move_decode.sv */
`timescale 1ns/1ps
module move_decode
  import move_exec_pkg::*;
(
  input  wire logic [13:0] insn,
  output op_kind_e         kind
);
  function automatic op_kind_e classify(input logic [13:0] w);
    if ((w & LOAD_LIT_MASK) == LOAD_LIT_PAT) classify = OP_LOAD_LIT;
    else if ((w & COPY_REG_MASK) == COPY_REG_PAT) classify = OP_COPY_REG;
    else if ((w & STORE_ACC_MASK) == STORE_ACC_PAT) classify = OP_STORE_ACC;
    else if ((w & IDLE_MASK) == IDLE_PAT) classify = OP_IDLE;
    else classify = OP_NONE;
  endfunction : classify

  always_comb begin
    kind = classify(insn);
  end
endmodule : move_decode

/* verilog/move_and_idle_instruction_exec.sv */
`timescale 1ns/1ps
// How it works
// - load literal opcode writes instruction low byte into accumulator
// - copy register with select clear puts file value into accumulator
// - copy register with select set writes value back to same register
// - copy register sets zero flag from the moved value, either destination
// - store accumulator writes accumulator to indexed register, flags untouched
module move_and_idle_instruction_exec
  import move_exec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        insn_valid,
  input  wire logic [13:0] insn,
  input  wire logic [7:0]  file_rdata,
  output logic [6:0]       file_raddr,
  output logic             file_we,
  output logic [6:0]       file_waddr,
  output logic [7:0]       file_wdata,
  output logic [7:0]       acc,
  output logic             zero_flag,
  output logic             done,
  output logic             unhandled
);
  op_kind_e kind;

  move_decode u_dec (
    .insn (insn),
    .kind (kind)
  );

  logic [7:0] acc_q,  acc_d;
  logic       z_q,    z_d;
  logic       we_q,   we_d;
  logic [6:0] wa_q,   wa_d;
  logic [7:0] wd_q,   wd_d;
  logic       done_q, done_d;
  logic       unh_q,  unh_d;
  logic [7:0] lit;
  logic       dest_sel;
  logic       take;

  // zero test shared by the flag logic and its cover
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  // read address is combinational from fetch so the file answers this cycle;
  // registering it would cost every copy a second cycle
  always_comb begin
    file_raddr = insn[FADDR_W-1:0];
    lit        = insn[DATA_W-1:0];
    dest_sel   = insn[DEST_BIT];
    take       = clk_en && insn_valid;
  end

  always_comb begin
    acc_d  = acc_q;
    z_d    = z_q;
    we_d   = 1'b0;
    wa_d   = wa_q;
    wd_d   = wd_q;
    done_d = 1'b0;
    unh_d  = 1'b0;
    if (insn_valid) begin
      done_d = (kind != OP_NONE);
      unh_d  = (kind == OP_NONE);
      case (kind)
        OP_LOAD_LIT: begin
          // x bits assumed zero by the image; decode ignores them anyway
          acc_d = lit;
        end
        OP_COPY_REG: begin
          z_d = is_zero(file_rdata);
          if (dest_sel) begin
            we_d = 1'b1;
            wa_d = insn[FADDR_W-1:0];
            wd_d = file_rdata;
          end else begin
            acc_d = file_rdata;
          end
        end
        OP_STORE_ACC: begin
          we_d = 1'b1;
          wa_d = insn[FADDR_W-1:0];
          wd_d = acc_q;
        end
        default: begin
          // idle and foreign opcodes leave state alone
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_q  <= ACC_RESET;
      z_q    <= ZERO_RESET;
      we_q   <= 1'b0;
      wa_q   <= WADDR_RESET;
      wd_q   <= WDATA_RESET;
      done_q <= 1'b0;
      unh_q  <= 1'b0;
    end else if (clk_en) begin
      acc_q  <= acc_d;
      z_q    <= z_d;
      we_q   <= we_d;
      wa_q   <= wa_d;
      wd_q   <= wd_d;
      done_q <= done_d;
      unh_q  <= unh_d;
    end
  end

  always_comb begin
    acc        = acc_q;
    zero_flag  = z_q;
    file_we    = we_q;
    file_waddr = wa_q;
    file_wdata = wd_q;
    done       = done_q;
    unhandled  = unh_q;
  end

  // checks; a frozen edge holds every registered output, so a pulse may stand longer
  // than one cycle of the clock while clk_en is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_LOAD_LIT: assert property (take && kind == OP_LOAD_LIT
    |=> acc == $past(lit))
    else $error("literal not loaded");

  AST_LOAD_SIDE: assert property (take && kind == OP_LOAD_LIT
    |=> $stable(zero_flag) && !file_we && done && !unhandled)
    else $error("literal load disturbed flag or file");

  AST_COPY_ACC: assert property (take && kind == OP_COPY_REG && !dest_sel
    |=> acc == $past(file_rdata) && !file_we)
    else $error("copy to acc wrong");

  AST_COPY_ACC_PORT: assert property (take && kind == OP_COPY_REG && !dest_sel
    |=> $stable(file_waddr) && $stable(file_wdata))
    else $error("copy to acc touched write port");

  AST_COPY_BACK: assert property (take && kind == OP_COPY_REG && dest_sel
    |=> file_we && file_waddr == $past(file_raddr) && file_wdata == $past(file_rdata))
    else $error("copy back wrong");

  AST_COPY_BACK_ACC: assert property (take && kind == OP_COPY_REG && dest_sel
    |=> $stable(acc))
    else $error("copy back changed acc");

  AST_ZERO: assert property (take && kind == OP_COPY_REG
    |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("zero flag wrong");

  AST_ZERO_SET: assert property (take && kind == OP_COPY_REG && file_rdata == 8'h00
    |=> zero_flag)
    else $error("zero flag not set");

  AST_ZERO_CLR: assert property (take && kind == OP_COPY_REG && file_rdata != 8'h00
    |=> !zero_flag)
    else $error("zero flag not cleared");

  AST_STORE: assert property (take && kind == OP_STORE_ACC
    |=> file_we && file_wdata == $past(acc) && $stable(zero_flag) && $stable(acc))
    else $error("store wrong");

  AST_STORE_ADDR: assert property (take && kind == OP_STORE_ACC
    |=> file_waddr == $past(file_raddr))
    else $error("store index wrong");

  AST_IDLE: assert property (take && kind == OP_IDLE
    |=> !file_we && $stable(acc) && $stable(zero_flag) && done)
    else $error("idle changed state");

  AST_IDLE_PORT: assert property (take && kind == OP_IDLE
    |=> $stable(file_waddr) && $stable(file_wdata) && !unhandled)
    else $error("idle touched write port");

  AST_ONE_CYCLE: assert property (take && kind != OP_NONE
    |=> done ##1 (!done || $past(insn_valid) || !$past(clk_en)))
    else $error("done not one cycle");

  AST_NO_INSN: assert property (clk_en && !insn_valid
    |=> !done && !unhandled && !file_we && $stable(acc) && $stable(zero_flag))
    else $error("state moved with no instruction");

  AST_FOREIGN: assert property (take && kind == OP_NONE
    |=> unhandled && !done && !file_we && $stable(acc) && $stable(zero_flag))
    else $error("foreign opcode changed state");

  AST_FREEZE: assert property (!clk_en |=> $stable(acc) && $stable(file_we) && $stable(done))
    else $error("state moved while disabled");

  AST_FREEZE_REST: assert property (!clk_en
    |=> $stable(zero_flag) && $stable(file_waddr) && $stable(file_wdata) && $stable(unhandled))
    else $error("port moved while disabled");

  AST_WE_DONE: assert property (file_we |-> done)
    else $error("write without a completed move");

  // reset is checked while it is asserted, so it opts out of the default disable
  AST_RESET: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_n
    |=> acc == ACC_RESET && zero_flag == ZERO_RESET && !file_we && !done && !unhandled
        && file_waddr == WADDR_RESET && file_wdata == WDATA_RESET)
    else $error("reset values wrong");

  COV_LOAD:  cover property (take && kind == OP_LOAD_LIT);
  COV_COPYZ: cover property (take && kind == OP_COPY_REG && is_zero(file_rdata));
  COV_STORE: cover property (take && kind == OP_STORE_ACC);
  COV_IDLE:  cover property (take && kind == OP_IDLE);
  COV_CHAIN: cover property ((take && kind == OP_LOAD_LIT) ##1 (take && kind == OP_STORE_ACC));
endmodule : move_and_idle_instruction_exec

/* tb/regfile_model.sv */
`timescale 1ns/1ps
module regfile_model (
  input  wire logic       clk_sys,
  input  wire logic [6:0] file_raddr,
  output logic      [7:0] file_rdata,
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];
  // known pattern; index 0x5a holds zero
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign file_rdata = mem[file_raddr];
  // write lands one edge late, so no bypass to a read at that edge
  always @(posedge clk_sys) if (file_we) mem[file_waddr] <= file_wdata;
endmodule : regfile_model

/* tb/test_move_and_idle_instruction_exec.sv */
`timescale 1ns/1ps
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, x, y); end end
module test_move_and_idle_instruction_exec;
  import move_exec_pkg::*;
  logic        clk_sys = 0, rst_n = 0, clk_en = 1, insn_valid = 0;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  file_rdata, file_wdata, acc, a, k, v, w;
  logic [6:0]  file_raddr, file_waddr, f, wa;
  logic        file_we, zero_flag, done, unhandled, z, we;
  logic [26:0] q[$], e;
  int          bad_count = 0, checks_done = 0, lw = 200, op;
  logic        en_last = 1'b0;
  logic [7:0]  mem_m [128];
  move_and_idle_instruction_exec move_and_idle_instruction_exec_inst (.clk_sys, .rst_n,
    .clk_en, .insn_valid, .insn, .file_rdata, .file_raddr, .file_we, .file_waddr,
    .file_wdata, .acc, .zero_flag, .done, .unhandled);
  regfile_model regfile_model_inst (.clk_sys, .file_raddr, .file_rdata, .file_we,
    .file_waddr, .file_wdata);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic tally_and_finish;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // a frozen edge holds done high; only an enabled edge yields a fresh result
  always @(posedge clk_sys) en_last <= clk_en;
  always @(negedge clk_sys) if (rst_n && en_last && (done || unhandled)) begin
    if (q.size() == 0) `CHK(1'b0, 1'b1)
    else begin
      e = q.pop_front();
      `CHK({done, unhandled, acc, zero_flag, file_we, file_waddr, file_wdata}, e)
    end
  end
  initial begin
    a = ACC_RESET;
    z = ZERO_RESET;
    wa = WADDR_RESET;
    w = WDATA_RESET;
    for (int i = 0; i < 128; i++) m_init(i);
    void'($urandom(32'hc068));
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    `CHK({acc, zero_flag, file_we, done}, {a, z, 2'b00})
    repeat (3000) begin
      op = $urandom % 6;
      f = 7'($urandom);
      k = 8'($urandom);
      // a copy right after a write to the same index would race the late write
      if (f == lw) f = f + 7'h01;
      clk_en = ($urandom % 8) != 0;
      insn_valid = ($urandom % 8) != 0;
      we = 0;
      lw = 200;
      case (op)
        0: insn = {6'h30, k};
        1, 2: insn = {6'h08, op == 2, f};
        3: insn = {7'h01, f};
        4: insn = 14'(($urandom % 4) << 5);
        default: insn = 14'h3800;
      endcase
      if (clk_en && insn_valid) begin
        case (op)
          0: a = k;
          1, 2: begin
            v = mem_m[f];
            z = v == 8'h00;
            if (op == 1) a = v;
            else begin we = 1; wa = f; w = v; lw = f; end
          end
          3: begin we = 1; wa = f; w = a; mem_m[f] = a; lw = f; end
          default: ;
        endcase
        q.push_back({op < 5, op == 5, a, z, we, wa, w});
      end
      @(negedge clk_sys);
    end
    insn_valid = 0;
    clk_en = 1;
    repeat (3) @(negedge clk_sys);
    `CHK(q.size(), 0)
    tally_and_finish();
  end
  function automatic void m_init(int i);
    mem_m[i] = 8'(i) ^ 8'h5a;
  endfunction : m_init
endmodule : test_move_and_idle_instruction_exec
